// ==== rtl/tofr_result_bank.sv ====
// downstream time-of-flight result bank, read by the host, loaded by the timing engine
// assumes the host read/write port and the engine run on the 40 MHz reference clock
`timescale 1ns/1ps
module tofr_result_bank
  import tofr_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  // timing engine results
  input  wire tofr_result_type         result,
  // host access
  input  wire tofr_host_req_type       host_req,
  output logic      [TOFR_REG_W-1:0]   rd_data_r,
  output logic                         rd_valid_r,
  output logic                         rd_hit_r,
  output logic                         wr_ignored_r,
  // measurement status
  output logic                         result_ready_r
);

  // ==========================================================
  // held fields
  logic [TOFR_RATIO_W-1:0] ratio_first_q;
  logic [TOFR_RATIO_W-1:0] ratio_second_q;
  logic [TOFR_INT_W-1:0]   hit1_int_q;
  logic [TOFR_FRAC_W-1:0]  hit1_frac_q;
  logic [TOFR_INT_W-1:0]   hit2_int_q;
  logic [TOFR_FRAC_W-1:0]  hit2_frac_q;
  logic                    load;
  logic [TOFR_REG_W-1:0]   rd_data_nxt;
  logic                    rd_hit_nxt;
  logic                    in_bank;

  // only a completed measurement loads; host writes never reach the fields
  assign load = result.valid;

  tofr_hold_reg #(.W(TOFR_RATIO_W)) u_ratio_first (
    .clock   (clock),
    .reset_n (reset_n),
    .load    (load),
    .d       (result.ratio_first),
    .q       (ratio_first_q)
  );

  tofr_hold_reg #(.W(TOFR_RATIO_W)) u_ratio_second (
    .clock   (clock),
    .reset_n (reset_n),
    .load    (load),
    .d       (result.ratio_second),
    .q       (ratio_second_q)
  );

  tofr_hold_reg #(.W(TOFR_INT_W)) u_hit1_int (
    .clock   (clock),
    .reset_n (reset_n),
    .load    (load),
    .d       (result.hit1_int),
    .q       (hit1_int_q)
  );

  tofr_hold_reg #(.W(TOFR_FRAC_W)) u_hit1_frac (
    .clock   (clock),
    .reset_n (reset_n),
    .load    (load),
    .d       (result.hit1_frac),
    .q       (hit1_frac_q)
  );

  tofr_hold_reg #(.W(TOFR_INT_W)) u_hit2_int (
    .clock   (clock),
    .reset_n (reset_n),
    .load    (load),
    .d       (result.hit2_int),
    .q       (hit2_int_q)
  );

  tofr_hold_reg #(.W(TOFR_FRAC_W)) u_hit2_frac (
    .clock   (clock),
    .reset_n (reset_n),
    .load    (load),
    .d       (result.hit2_frac),
    .q       (hit2_frac_q)
  );

  // ==========================================================
  // read decode
  always_comb begin
    rd_data_nxt = TOFR_REG_RST;
    rd_hit_nxt  = 1'b1;
    case (host_req.addr)
      // ratio bytes pass untouched: fixed point, msb weight 1
      TOFR_ADDR_RATIO:   rd_data_nxt = {ratio_first_q, ratio_second_q};
      TOFR_ADDR_H1_INT:  rd_data_nxt = {TOFR_INT_PAD, hit1_int_q};
      TOFR_ADDR_H1_FRAC: rd_data_nxt = hit1_frac_q;
      TOFR_ADDR_H2_INT:  rd_data_nxt = {TOFR_INT_PAD, hit2_int_q};
      TOFR_ADDR_H2_FRAC: rd_data_nxt = hit2_frac_q;
      default:           rd_hit_nxt  = 1'b0;
    endcase
  end

  assign in_bank = (host_req.addr >= TOFR_ADDR_RATIO) && (host_req.addr <= TOFR_ADDR_H2_FRAC);

  // ==========================================================
  // host read answer, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rd_data_r  <= TOFR_REG_RST;
      rd_valid_r <= 1'b0;
      rd_hit_r   <= 1'b0;
    end else begin
      rd_valid_r <= host_req.rd_en;
      rd_hit_r   <= host_req.rd_en && rd_hit_nxt;
      if (host_req.rd_en) begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  // ==========================================================
  // write refusal flag, so software can see the write had no effect
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wr_ignored_r <= 1'b0;
    end else begin
      wr_ignored_r <= host_req.wr_en && in_bank;
    end
  end

  // ==========================================================
  // measurement status: high once any result has been loaded
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      result_ready_r <= 1'b0;
    end else if (load) begin
      result_ready_r <= 1'b1;
    end
  end

  // ==========================================================
  // checks
  sequence s_load_then_read(logic [TOFR_ADDR_W-1:0] a);
    load ##1 (host_req.rd_en && host_req.addr == a && !load);
  endsequence

  property p_ratio_read;
    @(posedge clock) disable iff (!reset_n)
    host_req.rd_en && host_req.addr == TOFR_ADDR_RATIO
      |=> rd_hit_r && rd_data_r == {$past(ratio_first_q), $past(ratio_second_q)};
  endproperty
  a_ratio_read: assert property (p_ratio_read)
    else $error("ratio register read wrong");

  property p_ratio_bytes_kept;
    @(posedge clock) disable iff (!reset_n)
    s_load_then_read(TOFR_ADDR_RATIO)
      |=> rd_data_r[15:8] == $past(result.ratio_first, 2)
          && rd_data_r[7:0] == $past(result.ratio_second, 2);
  endproperty
  a_ratio_bytes_kept: assert property (p_ratio_bytes_kept)
    else $error("ratio bytes not carried unchanged");

  property p_hit1_int;
    @(posedge clock) disable iff (!reset_n)
    s_load_then_read(TOFR_ADDR_H1_INT)
      |=> rd_data_r[15] == TOFR_INT_PAD && rd_data_r[14:0] == $past(result.hit1_int, 2);
  endproperty
  a_hit1_int: assert property (p_hit1_int)
    else $error("first hit integer read wrong");

  property p_hit1_frac;
    @(posedge clock) disable iff (!reset_n)
    s_load_then_read(TOFR_ADDR_H1_FRAC) |=> rd_data_r == $past(result.hit1_frac, 2);
  endproperty
  a_hit1_frac: assert property (p_hit1_frac)
    else $error("first hit fraction read wrong");

  property p_hit2_int;
    @(posedge clock) disable iff (!reset_n)
    s_load_then_read(TOFR_ADDR_H2_INT)
      |=> rd_data_r[15] == TOFR_INT_PAD && rd_data_r[14:0] == $past(result.hit2_int, 2);
  endproperty
  a_hit2_int: assert property (p_hit2_int)
    else $error("second hit integer read wrong");

  property p_hit2_frac;
    @(posedge clock) disable iff (!reset_n)
    s_load_then_read(TOFR_ADDR_H2_FRAC) |=> rd_data_r == $past(result.hit2_frac, 2);
  endproperty
  a_hit2_frac: assert property (p_hit2_frac)
    else $error("second hit fraction read wrong");

  property p_hold_without_load;
    @(posedge clock) disable iff (!reset_n)
    !load |=> $stable(hit1_int_q) && $stable(hit1_frac_q) && $stable(hit2_int_q)
              && $stable(hit2_frac_q) && $stable(ratio_first_q) && $stable(ratio_second_q);
  endproperty
  a_hold_without_load: assert property (p_hold_without_load)
    else $error("result changed without a measurement");

  property p_write_flagged;
    @(posedge clock) disable iff (!reset_n)
    host_req.wr_en && host_req.addr == TOFR_ADDR_H1_INT && !load
      |=> wr_ignored_r && $stable(hit1_int_q);
  endproperty
  a_write_flagged: assert property (p_write_flagged)
    else $error("host write not ignored");

  property p_unmapped_zero;
    @(posedge clock) disable iff (!reset_n)
    host_req.rd_en && host_req.addr > TOFR_ADDR_H2_FRAC
      |=> rd_valid_r && !rd_hit_r && rd_data_r == TOFR_REG_RST;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  // the status flag must follow the very first completed measurement
  property p_ready_after_load;
    @(posedge clock) disable iff (!reset_n)
    load |=> result_ready_r;
  endproperty
  a_ready_after_load: assert property (p_ready_after_load)
    else $error("ready flag not set by a load");

endmodule : tofr_result_bank

// ==== rtl/tofr_pkg.sv ====
// constants and carrier types of the downstream time-of-flight result bank
// assumes one 40 MHz reference clock shared by the bank, the timing engine and the host port
package tofr_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] TOFR_ADDR_RATIO   = 8'hD3;
  localparam logic [7:0] TOFR_ADDR_H1_INT  = 8'hD4;
  localparam logic [7:0] TOFR_ADDR_H1_FRAC = 8'hD5;
  localparam logic [7:0] TOFR_ADDR_H2_INT  = 8'hD6;
  localparam logic [7:0] TOFR_ADDR_H2_FRAC = 8'hD7;

  // ==========================================================
  // field layout
  localparam int TOFR_REG_W   = 16;
  localparam int TOFR_RATIO_W = 8;
  localparam int TOFR_INT_W   = 15;
  localparam int TOFR_FRAC_W  = 16;
  localparam int TOFR_ADDR_W  = 8;

  // largest integer count a hit can report
  localparam logic [TOFR_INT_W-1:0] TOFR_INT_MAX = 15'h7FFF;

  // ==========================================================
  // reset values
  localparam logic [TOFR_REG_W-1:0]   TOFR_REG_RST   = 16'h0000;
  localparam logic [TOFR_RATIO_W-1:0] TOFR_RATIO_RST = 8'h00;
  localparam logic [TOFR_INT_W-1:0]   TOFR_INT_RST   = 15'h0000;
  localparam logic [TOFR_FRAC_W-1:0]  TOFR_FRAC_RST  = 16'h0000;
  localparam logic                    TOFR_INT_PAD   = 1'b0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic                    valid;
    logic [TOFR_RATIO_W-1:0] ratio_first;
    logic [TOFR_RATIO_W-1:0] ratio_second;
    logic [TOFR_INT_W-1:0]   hit1_int;
    logic [TOFR_FRAC_W-1:0]  hit1_frac;
    logic [TOFR_INT_W-1:0]   hit2_int;
    logic [TOFR_FRAC_W-1:0]  hit2_frac;
  } tofr_result_type;

  typedef struct packed {
    logic                   rd_en;
    logic                   wr_en;
    logic [TOFR_ADDR_W-1:0] addr;
    logic [TOFR_REG_W-1:0]  wr_data;
  } tofr_host_req_type;

endpackage : tofr_pkg

// ==== rtl/tofr_hold_reg.sv ====
// one result field held between measurements
// assumes load is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
module tofr_hold_reg
  import tofr_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         reset_n,
  // load side
  input  wire logic         load,
  input  wire logic [W-1:0] d,
  // held value
  output logic      [W-1:0] q
);

  // ==========================================================
  // storage
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      q <= '0;
    end else if (load) begin
      q <= d;
    end
  end

endmodule : tofr_hold_reg

// ==== tb/tofr_host_model.sv ====
// host-side model of the result bank's read/write strobe port
// assumes requests launch on the falling edge and answers land one rising edge later
`timescale 1ns/1ps
module tofr_host_model
  import tofr_pkg::*;
(
  // clock
  input  wire logic                  clock,
  // request side
  output tofr_host_req_type          host_req,
  // answer side
  input  wire logic [TOFR_REG_W-1:0] rd_data_r,
  input  wire logic                  rd_valid_r,
  input  wire logic                  rd_hit_r,
  input  wire logic                  wr_ignored_r
);
  initial host_req = '0;

  // ==========================================================
  // idle: stale address and data inverted so they never pose as live
  task automatic idle();
    host_req.rd_en   = 1'b0;
    host_req.wr_en   = 1'b0;
    host_req.addr    = ~host_req.addr;
    host_req.wr_data = ~host_req.wr_data;
  endtask : idle

  task automatic read(input logic [7:0] a, output logic [15:0] d, output logic v, output logic h);
    @(negedge clock);
    host_req.rd_en = 1'b1;
    host_req.addr  = a;
    @(negedge clock);
    d = rd_data_r;
    v = rd_valid_r;
    h = rd_hit_r;
    idle();
  endtask : read

  task automatic write(input logic [7:0] a, input logic [15:0] wd, output logic ign);
    @(negedge clock);
    host_req.wr_en   = 1'b1;
    host_req.addr    = a;
    host_req.wr_data = wd;
    @(negedge clock);
    ign = wr_ignored_r;
    idle();
  endtask : write
endmodule : tofr_host_model

// ==== tb/tb_downstream_tof_result_regs.sv ====
// self-checking bench for the downstream result bank
// assumes the host model drives the read/write port; the bench plays the timing engine
`timescale 1ns/1ps
module tb_downstream_tof_result_regs;
  import tofr_pkg::*;
  logic              clock;
  logic              reset_n;
  tofr_result_type   result;
  tofr_host_req_type host_req;
  logic [15:0]       rd_data_r;
  logic              rd_valid_r;
  logic              rd_hit_r;
  logic              wr_ignored_r;
  logic              result_ready_r;
  int                err_total;
  int                comparisons;
  logic [15:0]       exp_regs [5];
  logic [15:0]       d;
  logic              v;
  logic              h;
  logic              ign;

  tofr_result_bank uut (.clock(clock), .reset_n(reset_n), .result(result),
    .host_req(host_req), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .rd_hit_r(rd_hit_r), .wr_ignored_r(wr_ignored_r), .result_ready_r(result_ready_r));
  tofr_host_model host (.clock(clock), .host_req(host_req), .rd_data_r(rd_data_r),
    .rd_valid_r(rd_valid_r), .rd_hit_r(rd_hit_r), .wr_ignored_r(wr_ignored_r));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // engine load: one valid pulse, all six fields together
  task automatic load(input logic [7:0] rf, rs, input logic [14:0] i1, input logic [15:0] f1,
                      input logic [14:0] i2, input logic [15:0] f2);
    @(negedge clock);
    result = {1'b1, rf, rs, i1, f1, i2, f2};
    exp_regs = '{{rf, rs}, {1'b0, i1}, f1, {1'b0, i2}, f2};
    @(negedge clock);
    result.valid = 1'b0;
  endtask : load

  task automatic read_chk(input logic [7:0] a, input logic [15:0] exp, input logic hit);
    host.read(a, d, v, h);
    check("rd_data_r", d, exp);
    check("rd_valid_r", {15'h0000, v}, 16'h0001);
    check("rd_hit_r", {15'h0000, h}, {15'h0000, hit});
  endtask : read_chk

  task automatic check_bank();
    for (int i = 0; i < 5; i++) read_chk(8'hD3 + 8'(i), exp_regs[i], 1'b1);
  endtask : check_bank

  // a read one cycle after a load must already return the new fields
  task automatic check_fresh();
    tofr_result_type r;
    logic [15:0]     e [5];
    r = result;
    e = exp_regs;
    for (int i = 0; i < 5; i++) begin
      load(~r.ratio_first, ~r.ratio_second, ~r.hit1_int, ~r.hit1_frac, ~r.hit2_int,
           ~r.hit2_frac);
      fork
        load(r.ratio_first, r.ratio_second, r.hit1_int, r.hit1_frac, r.hit2_int, r.hit2_frac);
        begin
          @(negedge clock);
          read_chk(8'hD3 + 8'(i), e[i], 1'b1);
        end
      join
    end
  endtask : check_fresh

  // ==========================================================
  // scenarios
  task automatic test_reset_values();
    exp_regs = '{default: 16'h0000};
    check_bank();
    check("result_ready_r", {15'h0000, result_ready_r}, 16'h0000);
    $display("test_reset_values done");
  endtask : test_reset_values

  task automatic test_field_map();
    // 1.5 and the lsb weight, worked out from the fixed-point weights
    load(8'($rtoi(1.5 * 128.0)), 8'($rtoi(0.0078125 * 128.0)), 15'h7FFF, 16'hFFFF,
         15'h0001, 16'h8000);
    read_chk(TOFR_ADDR_RATIO, 16'hC001, 1'b1);
    check_bank();
    check_fresh();
    check("result_ready_r", {15'h0000, result_ready_r}, 16'h0001);
    $display("test_field_map done");
  endtask : test_field_map

  task automatic test_writes_ignored();
    for (int i = 0; i < 5; i++) begin
      host.write(8'hD3 + 8'(i), 16'h5A5A, ign);
      check("wr_ignored_r", {15'h0000, ign}, 16'h0001);
    end
    host.write(8'hD8, 16'hA5A5, ign);
    check("wr_ignored_r", {15'h0000, ign}, 16'h0000);
    check_bank();
    $display("test_writes_ignored done");
  endtask : test_writes_ignored

  task automatic test_unmapped_reads();
    read_chk(8'hD2, 16'h0000, 1'b0);
    read_chk(8'hD8, 16'h0000, 1'b0);
    read_chk(8'hFF, 16'h0000, 1'b0);
    $display("test_unmapped_reads done");
  endtask : test_unmapped_reads

  task automatic test_reload();
    // hold until next completion, then all fields replaced together
    repeat (10) @(negedge clock);
    check_bank();
    load(8'hFF, 8'h80, 15'h0000, 16'h0001, 15'h4000, 16'h7FFF);
    check_bank();
    check_fresh();
    $display("test_reload done");
  endtask : test_reload

  // ==========================================================
  // main sequence and watchdog
  initial begin
    err_total = 0;
    comparisons = 0;
    result = '0;
    reset_n = 1'b0;
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    test_reset_values();
    test_field_map();
    test_writes_ignored();
    test_unmapped_reads();
    test_reload();
    report_and_stop();
  end

  initial begin
    #(25.0 * 2000);
    err_total++;
    report_and_stop();
  end
endmodule : tb_downstream_tof_result_regs
